/* File: hdl/kms_pkg.sv */
// ----------------------------------------------------------------------------
// Key matrix scanner constants and types
// ----------------------------------------------------------------------------
package kms_pkg;

    // Matrix geometry and storage sizes.
    localparam int KMS_MAX_COLS = 20;
    localparam int KMS_MAX_ROWS = 8;
    localparam int KMS_KEYS = 160;
    localparam int KMS_Q_DEPTH = 16;
    localparam int KMS_OB_DEPTH = 2;
    localparam int KMS_MODS = 4;

    // Scan clock derived from the 100 MHz system clock.
    localparam int KMS_MCLK_HZ = 100_000_000;
    localparam int KMS_SCAN_HZ = 128_000;
    localparam int KMS_TICK_CYCLES = KMS_MCLK_HZ / KMS_SCAN_HZ;
    localparam logic [9:0] KMS_TICK_LAST = 10'(KMS_TICK_CYCLES - 1);

    // Sized constants used by the scanner logic.
    localparam logic [4:0] KMS_Q_FULL = 5'h10;
    localparam logic [1:0] KMS_OB_FULL = 2'h2;
    localparam logic [3:0] KMS_ROWS_MAX = 4'h8;
    localparam logic [4:0] KMS_COLS_MAX = 5'h14;
    localparam logic [19:0] KMS_COL_ONE = 20'h00001;
    localparam logic [19:0] KMS_COLS_IDLE = 20'hfffff;

    typedef enum logic [1:0] {
        KMS_IDLE = 2'b00,
        KMS_SCAN = 2'b01,
        KMS_END = 2'b10
    } kms_state_e;

    // Static configuration from the host.
    typedef struct packed {
        logic [4:0] cols;
        logic [3:0] rows;
        logic [1:0] debounce;
        logic [KMS_MODS-1:0][7:0] mod_code;
    } kms_cfg_s;

    // Status seen by the polling host.
    typedef struct packed {
        logic key_avail;
        logic ghost;
        logic overflow;
        logic [KMS_MODS-1:0] mods;
        logic scanning;
    } kms_status_s;

    // Complete state of the scanner.
    typedef struct packed {
        kms_state_e st;
        logic [9:0] tick_cnt;
        logic [2:0] row;
        logic [4:0] col;
        logic [7:0] kidx;
        logic [7:0] row_hit;
        logic [7:0] col_mask;
        logic col_multi;
        logic found;
        logic clk_req;
        logic [19:0] col_drive;
        logic [7:0] row_prev;
        logic [7:0] rq1;
        logic [7:0] rq2;
        logic [KMS_KEYS-1:0] key_state;
        logic [KMS_KEYS-1:0][1:0] deb;
        logic [KMS_MODS-1:0] mods;
        logic ghost;
        logic ovf;
        logic [KMS_Q_DEPTH-1:0][7:0] q_mem;
        logic [3:0] q_wr;
        logic [3:0] q_rd;
        logic [4:0] q_cnt;
        logic [KMS_OB_DEPTH-1:0][7:0] ob_data;
        logic ob_head;
        logic [1:0] ob_cnt;
    } kms_state_s;

endpackage : kms_pkg

/* File: hdl/kms_scanner.sv */
// Behaviour
// R1 - Column count is programmable from one to twenty.
// R2 - Row count is programmable from one to eight.
// R3 - Key codes wait in a sixteen-byte queue until read or overflow.
// R4 - One matrix position is scanned per 128 kHz tick.
// R5 - Idle state is entered first and drives all columns high.
// R6 - Row change in idle requests clock unless shared, then starts scanning.
// R7 - Idle clears the row-hit accumulator and key-index counter.
// R8 - Row counter wraps at row count and advances the column counter.
// R9 - Both counters terminal moves the scan to scan-end.
// R10 - Key index steps per position; matched to modifiers or queued.
// R11 - Columns with two or more hits OR their rows into row-hit.
// R12 - Press in a column of two or more hits, on a row already hit earlier, sets the ghost flag.
// R13 - Scan-end rescans if keys were found, else idles dropping request.
// R14 - All keys reported, but ghost-pattern presses are locked out.
// R15 - Row samples are glitch filtered and debounced before reporting.
// R16 - Host polls status and then reads queued key codes.
// R17 - Changes report only after configured consecutive matching scans.
// R18 - Code arriving on full queue is dropped and sets overflow.
`timescale 1ns/1ps
`default_nettype none

module kms_scanner
    import kms_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire kms_cfg_s cfg,
    input wire logic [7:0] row_in,
    input wire logic clk_shared_on,
    input wire logic ghost_clr,
    input wire logic ovf_clr,
    input wire logic key_ready,
    output logic [19:0] col_out,
    output logic clk_req,
    output logic key_valid,
    output logic [7:0] key_code,
    output kms_status_s status
);

    // ------------------------------------------------------------------------
    // State and working signals
    // ------------------------------------------------------------------------
    kms_state_s s;
    kms_state_s next_s;
    logic tick;
    logic proc;
    logic [7:0] filt;
    logic [3:0] rows_eff;
    logic [4:0] cols_eff;
    logic [1:0] deb_eff;
    logic [7:0] rows_mask;
    logic [7:0] cur_mask;
    logic [7:0] colm;
    logic multi;
    logic colm_multi;
    logic pressed;
    logic old_state;
    logic [1:0] dcnt;
    logic ghost_hit;
    logic lock;
    logic deb_done;
    logic push;
    logic q_full;
    logic q_pop;
    logic host_pop;
    logic last_row;
    logic last_col;
    logic [KMS_MODS-1:0] mod_match;
    logic is_mod;

    // Each modifier slot compares its stored code with the key index.
    genvar gi;
    generate
        for (gi = 0; gi < KMS_MODS; gi = gi + 1) begin : g_mod
            assign mod_match[gi] = (cfg.mod_code[gi] == s.kidx); // see R10
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    // Computes the whole next state from the current one and the inputs.
    always_comb begin
        next_s = s;
        tick = 1'b0;
        proc = 1'b0;
        pressed = 1'b0;
        ghost_hit = 1'b0;
        lock = 1'b0;
        deb_done = 1'b0;
        push = 1'b0;
        is_mod = |mod_match;

        // Three-sample majority removes single-cycle glitches on the rows.
        next_s.rq1 = row_in;
        next_s.rq2 = s.rq1;
        filt = (row_in & s.rq1) | (row_in & s.rq2) | (s.rq1 & s.rq2); // see R15

        // Out-of-range settings are clamped to the legal span.
        rows_eff = (cfg.rows == 4'h0) ? 4'h1 :
                   ((cfg.rows > KMS_ROWS_MAX) ? KMS_ROWS_MAX : cfg.rows); // see R2
        cols_eff = (cfg.cols == 5'h00) ? 5'h01 :
                   ((cfg.cols > KMS_COLS_MAX) ? KMS_COLS_MAX : cfg.cols); // see R1
        deb_eff = (cfg.debounce == 2'h0) ? 2'h1 : cfg.debounce;
        rows_mask = 8'((9'h001 << rows_eff) - 9'h001);

        // Rows are active low; a pressed key pulls its row down.
        cur_mask = ~filt & rows_mask;
        multi = |(cur_mask & (cur_mask - 8'h01));
        colm = (s.row == 3'h0) ? cur_mask : s.col_mask;
        colm_multi = (s.row == 3'h0) ? multi : s.col_multi;
        last_row = ({1'b0, s.row} == (rows_eff - 4'h1));
        last_col = (s.col == (cols_eff - 5'h01));
        old_state = s.key_state[s.kidx];
        dcnt = s.deb[s.kidx];

        // The tick divider runs only while some user holds the scan clock.
        if (s.clk_req | clk_shared_on) begin
            if (s.tick_cnt == KMS_TICK_LAST) begin
                next_s.tick_cnt = '0;
                tick = 1'b1; // see R4
            end else begin
                next_s.tick_cnt = s.tick_cnt + 10'h001;
            end
        end else begin
            next_s.tick_cnt = '0;
        end

        case (s.st)
            KMS_IDLE: begin
                next_s.row_hit = '0; // see R7
                next_s.kidx = '0; // see R7
                next_s.row = '0;
                next_s.col = '0;
                next_s.row_prev = filt;
                if (filt != s.row_prev) begin
                    next_s.st = KMS_SCAN; // see R6
                    next_s.found = 1'b0;
                end
            end
            KMS_SCAN: begin
                if (tick) begin
                    proc = 1'b1;
                    pressed = ~filt[s.row];
                    ghost_hit = pressed & s.row_hit[s.row] & colm_multi; // see R12
                    lock = ghost_hit & ~old_state; // see R14
                    next_s.col_mask = colm;
                    next_s.col_multi = colm_multi;
                    if (pressed) begin
                        next_s.found = 1'b1;
                    end
                    if (ghost_hit) begin
                        next_s.ghost = 1'b1; // see R12
                    end
                    // A change must persist for deb_eff scans to be taken.
                    if ((pressed == old_state) || lock) begin
                        next_s.deb[s.kidx] = 2'h0;
                    end else if (({1'b0, dcnt} + 3'h1) >= {1'b0, deb_eff}) begin
                        deb_done = 1'b1; // see R17
                        next_s.deb[s.kidx] = 2'h0;
                        next_s.key_state[s.kidx] = pressed;
                        if (is_mod) begin
                            next_s.mods = (s.mods & ~mod_match) |
                                          (mod_match & {KMS_MODS{pressed}}); // see R10
                        end else begin
                            push = pressed; // see R10
                        end
                    end else begin
                        next_s.deb[s.kidx] = dcnt + 2'h1;
                        next_s.found = 1'b1;
                    end
                    next_s.kidx = s.kidx + 8'h01; // see R10
                    if (last_row) begin
                        next_s.row = '0; // see R8
                        if (colm_multi) begin
                            next_s.row_hit = s.row_hit | colm; // see R11
                        end
                        if (last_col) begin
                            next_s.st = KMS_END; // see R9
                        end else begin
                            next_s.col = s.col + 5'h01; // see R8
                        end
                    end else begin
                        next_s.row = s.row + 3'h1; // see R8
                    end
                end
            end
            KMS_END: begin
                next_s.kidx = '0;
                next_s.row_hit = '0;
                next_s.row = '0;
                next_s.col = '0;
                next_s.row_prev = filt;
                if (s.found) begin
                    next_s.st = KMS_SCAN; // see R13
                    next_s.found = 1'b0;
                end else begin
                    next_s.st = KMS_IDLE; // see R13
                end
            end
            default: begin
                next_s.st = KMS_IDLE;
            end
        endcase

        // Clock is requested outside idle unless another user already runs it.
        next_s.clk_req = (next_s.st != KMS_IDLE) & ~clk_shared_on; // see R6
        // Idle drives every column high; scan pulls only the active one low.
        next_s.col_drive = (next_s.st == KMS_SCAN) ?
                           ~(KMS_COL_ONE << next_s.col) : KMS_COLS_IDLE; // see R5

        // Queue push drops the code on a full queue and flags overflow.
        q_full = (s.q_cnt == KMS_Q_FULL);
        q_pop = (s.q_cnt != 5'h00) && (s.ob_cnt != KMS_OB_FULL);
        host_pop = key_ready && (s.ob_cnt != 2'h0); // see R16
        next_s.ovf = s.ovf & ~ovf_clr;
        next_s.ghost = next_s.ghost & ~(ghost_clr & ~ghost_hit);
        if (push & q_full) begin
            next_s.ovf = 1'b1; // see R18
        end
        if (push & ~q_full) begin
            next_s.q_mem[s.q_wr] = s.kidx; // see R3
            next_s.q_wr = s.q_wr + 4'h1;
        end
        if (q_pop) begin
            next_s.ob_data[s.ob_head ^ s.ob_cnt[0]] = s.q_mem[s.q_rd];
            next_s.q_rd = s.q_rd + 4'h1;
        end
        next_s.q_cnt = s.q_cnt + {4'h0, push & ~q_full} - {4'h0, q_pop}; // see R3

        // Two-entry output buffer toward the host.
        if (host_pop) begin
            next_s.ob_head = ~s.ob_head;
        end
        next_s.ob_cnt = s.ob_cnt + {1'b0, q_pop} - {1'b0, host_pop};
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Registers the whole state; columns idle high from reset.
    // Row history resets to the released level so no false wake follows reset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.col_drive <= KMS_COLS_IDLE; // see R5
            s.rq1 <= '1;
            s.rq2 <= '1;
            s.row_prev <= '1; // see R6
        end else begin
            s <= next_s;
        end
    end

    // Outputs are taken from the state register.
    assign col_out = s.col_drive;
    assign clk_req = s.clk_req;
    assign key_valid = (s.ob_cnt != 2'h0);
    assign key_code = s.ob_data[s.ob_head];
    assign status = '{key_avail: (s.ob_cnt != 2'h0), ghost: s.ghost, overflow: s.ovf,
                      mods: s.mods, scanning: (s.st != KMS_IDLE)};

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_idle_empty;
        (s.st == KMS_END) && !s.found;
    endsequence

    sequence s_back_idle;
        (s.st == KMS_IDLE) && !s.clk_req;
    endsequence

    property p_idle_cols;
        (s.st == KMS_IDLE) |-> (col_out == KMS_COLS_IDLE);
    endproperty
    a_idle_cols: assert property (p_idle_cols) else $error("columns not high in idle"); // see R5

    property p_wake;
        (s.st == KMS_IDLE) && (filt != s.row_prev) |=>
            (s.st == KMS_SCAN) && (clk_req == !$past(clk_shared_on));
    endproperty
    a_wake: assert property (p_wake) else $error("row change did not start scan"); // see R6

    property p_idle_clear;
        (s.st == KMS_IDLE) ##1 (s.st == KMS_IDLE) |-> (s.kidx == 8'h00) && (s.row_hit == 8'h00);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle counters not cleared"); // see R7

    property p_wrap;
        proc && last_row && !last_col |=> (s.row == 3'h0) && (s.col == $past(s.col) + 5'h01);
    endproperty
    a_wrap: assert property (p_wrap) else $error("row wrap did not step column"); // see R8

    property p_range;
        (s.st == KMS_SCAN) |-> ({1'b0, s.row} < rows_eff) && (s.col < cols_eff);
    endproperty
    a_range: assert property (p_range) else $error("counter beyond programmed size"); // see R1

    property p_terminal;
        proc && last_row && last_col |=> (s.st == KMS_END);
    endproperty
    a_terminal: assert property (p_terminal) else $error("terminal count missed"); // see R9

    property p_kidx;
        proc |=> (s.kidx == $past(s.kidx) + 8'h01);
    endproperty
    a_kidx: assert property (p_kidx) else $error("key index did not advance"); // see R10

    property p_rowhit;
        proc && last_row && colm_multi |=> ((s.row_hit & $past(colm)) == $past(colm));
    endproperty
    a_rowhit: assert property (p_rowhit) else $error("row hits not accumulated"); // see R11

    property p_ghost;
        ghost_hit |=> s.ghost;
    endproperty
    a_ghost: assert property (p_ghost) else $error("ghost flag not set"); // see R12

    property p_end_idle;
        s_idle_empty |=> s_back_idle;
    endproperty
    a_end_idle: assert property (p_end_idle) else $error("empty pass did not idle"); // see R13

    property p_lockout;
        lock |-> !push && !deb_done;
    endproperty
    a_lockout: assert property (p_lockout) else $error("ghost key was reported"); // see R14

    property p_tick_gap;
        tick |=> !tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("scan ticks too close"); // see R4

    property p_debounce;
        deb_done |-> (({1'b0, dcnt} + 3'h1) >= {1'b0, deb_eff}) && (pressed != old_state);
    endproperty
    a_debounce: assert property (p_debounce) else $error("change taken before debounce"); // see R17

    property p_overflow;
        push && q_full |=> s.ovf && (s.q_cnt <= KMS_Q_FULL);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // see R18

    property p_qbound;
        s.q_cnt <= KMS_Q_FULL;
    endproperty
    a_qbound: assert property (p_qbound) else $error("queue count above depth"); // see R3

endmodule : kms_scanner

`default_nettype wire

/* File: verification/kms_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Key switch matrix and polling host
// ----------------------------------------------------------------------------
module kms_partner (
    input wire logic mclk,
    input wire logic [19:0] col_out,
    input wire logic [19:0][7:0] pressed,
    input wire logic stall,
    input wire logic key_valid,
    input wire logic [7:0] key_code,
    output logic [7:0] row_in,
    output logic key_ready
);
    logic [7:0] got[$];

    // A closed switch pulls its row low while its column is low; rows have pull-ups.
    // With every column high the whole matrix is sensed, so a press can wake the scanner.
    always_comb begin
        row_in = 8'hff;
        for (int c = 0; c < 20; c++) begin
            if (!col_out[c] || col_out == 20'hfffff) begin
                row_in = row_in & ~pressed[c];
            end
        end
    end

    // The host takes a code whenever it is not told to stall.
    assign key_ready = !stall;

    // Every code taken by the host is kept in arrival order.
    always @(posedge mclk) begin
        if (key_valid && key_ready) begin
            got.push_back(key_code);
        end
    end
endmodule : kms_partner

`default_nettype wire

/* File: verification/test_kms_scanner.sv */
`timescale 1ns/1ps
`default_nettype none

module test_kms_scanner
    import kms_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    kms_cfg_s cfg;
    logic clk_shared_on, ghost_clr, ovf_clr, stall, key_ready, clk_req, key_valid;
    logic [7:0] row_in, key_code;
    logic [19:0] col_out, lowmask;
    logic [19:0][7:0] pressed;
    kms_status_s status;
    int num_errors = 0;
    int checks = 0;

    // ------------------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------------------
    always #5 mclk = ~mclk;

    // Collects every column that has been driven low since the last clear.
    always @(negedge mclk) lowmask = lowmask | ~col_out;

    kms_scanner dut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .row_in(row_in),
        .clk_shared_on(clk_shared_on), .ghost_clr(ghost_clr), .ovf_clr(ovf_clr),
        .key_ready(key_ready), .col_out(col_out), .clk_req(clk_req),
        .key_valid(key_valid), .key_code(key_code), .status(status));

    kms_partner pm (.mclk(mclk), .col_out(col_out), .pressed(pressed), .stall(stall),
        .key_valid(key_valid), .key_code(key_code), .row_in(row_in),
        .key_ready(key_ready));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic finish_test;
        $display("Counts: %0d comparisons, %0d mismatches", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_range(input int got, input int lo, input int hi, input string what);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("BAD %0t %s: %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : chk_range

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    // Waits for idle (0), scanning (1) or the end of the first column (2).
    task automatic wait_on(input int which, input int lim, output int n);
        bit hit;
        n = 0;
        hit = 0;
        while (!hit) begin
            @(negedge mclk);
            n++;
            case (which)
                0: hit = (status.scanning === 1'b0 && clk_req === 1'b0);
                1: hit = (status.scanning === 1'b1);
                default: hit = (col_out[0] === 1'b1);
            endcase
            if (!hit && n >= lim) begin
                num_errors++;
                $display("BAD %0t wait %0d ran out", $time, which);
                finish_test();
            end
        end
    endtask : wait_on

    // Sets the geometry and clears the history before a scenario.
    task automatic setup(input logic [4:0] cols, input logic [3:0] rows);
        int n;
        wait_on(0, 40000, n);
        cfg.cols = cols;
        cfg.rows = rows;
        pm.got.delete();
        @(posedge mclk) lowmask = '0;
        @(negedge mclk);
    endtask : setup

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        int n;
        chk(col_out, 20'hfffff, "columns in reset");
        chk(clk_req, 1'b0, "request in reset");
        chk(status, '0, "status in reset");
        rst_n = 1'b1;
        cyc(2);
        chk(col_out, 20'hfffff, "columns after reset");
        wait_on(0, 20000, n);
        pressed[0][0] = 1'b1;
        @(negedge mclk);
        pressed[0][0] = 1'b0;
        cyc(10);
        chk(status.scanning, 1'b0, "glitch woke scanner");
        $display("test reset done");
    endtask : t_reset

    task automatic t_order;
        int n;
        setup(5'h02, 4'h3);
        pressed[0][2] = 1'b1;
        pressed[1][1] = 1'b1;
        wait_on(1, 20, n);
        chk(clk_req, 1'b1, "clock request on wake");
        chk(col_out, 20'hffffe, "first column");
        wait_on(2, 3000, n);
        chk_range(n, 3 * KMS_TICK_CYCLES - 3, 3 * KMS_TICK_CYCLES + 3, "column time");
        cyc(6 * 781 + 2000);
        pressed = '0;
        wait_on(0, 20000, n);
        chk(pm.got.size(), 2, "code count");
        chk(pm.got[0], 8'h02, "first code");
        chk(pm.got[1], 8'h04, "second code");
        chk(lowmask, 20'h00003, "columns scanned");
        chk(col_out, 20'hfffff, "columns back in idle");
        chk(clk_req, 1'b0, "request dropped");
        $display("test order done");
    endtask : t_order

    task automatic t_shared;
        int n;
        setup(5'h01, 4'h2);
        clk_shared_on = 1'b1;
        pressed[0][1] = 1'b1;
        wait_on(1, 20, n);
        cyc(3);
        chk(clk_req, 1'b0, "no request while shared");
        cyc(2 * 781 + 2000);
        pressed = '0;
        wait_on(0, 20000, n);
        chk(pm.got.size(), 1, "shared code count");
        chk(pm.got[0], 8'h01, "shared code");
        chk(lowmask, 20'h00001, "single column");
        clk_shared_on = 1'b0;
        $display("test shared clock done");
    endtask : t_shared

    task automatic t_mod;
        int n;
        setup(5'h01, 4'h2);
        cfg.debounce = 2'h2;
        cfg.mod_code[0] = 8'h01;
        pressed[0][1] = 1'b1;
        wait_on(1, 20, n);
        cyc(1700);
        chk(status.mods[0], 1'b0, "modifier before second pass");
        cyc(1700);
        chk(status.mods[0], 1'b1, "modifier held");
        pressed = '0;
        wait_on(0, 20000, n);
        chk(status.mods[0], 1'b0, "modifier released");
        chk(pm.got.size(), 0, "modifier not queued");
        cfg.debounce = 2'h1;
        cfg.mod_code[0] = 8'hff;
        $display("test modifier done");
    endtask : t_mod

    task automatic t_ghost;
        int n;
        setup(5'h02, 4'h2);
        pressed[0] = 8'h03;
        pressed[1] = 8'h03;
        wait_on(1, 20, n);
        cyc(2 * 4 * 781 + 500);
        chk(status.ghost, 1'b1, "ghost flag");
        pressed = '0;
        wait_on(0, 20000, n);
        chk(pm.got.size(), 2, "ghost codes locked out");
        chk(pm.got[1], 8'h01, "column with hits reported");
        ghost_clr = 1'b1;
        @(negedge mclk);
        ghost_clr = 1'b0;
        cyc(2);
        chk(status.ghost, 1'b0, "ghost cleared");
        $display("test ghost done");
    endtask : t_ghost

    task automatic t_ovf;
        int n;
        setup(5'h01, 4'h8);
        stall = 1'b1;
        // Each batch is released after one full pass and the scanner idles before the next.
        for (int b = 0; b < 3; b++) begin
            pressed[0] = 8'hff;
            cyc(8 * KMS_TICK_CYCLES + 100);
            pressed = '0;
            wait_on(0, 20000, n);
        end
        chk(status.overflow, 1'b1, "overflow flag");
        chk(key_valid, 1'b1, "codes held for host");
        chk(status.key_avail, 1'b1, "status shows codes");
        stall = 1'b0;
        cyc(50);
        chk(pm.got.size(), 18, "codes kept");
        chk(key_valid, 1'b0, "buffer drained");
        chk(status.key_avail, 1'b0, "status shows empty");
        chk(pm.got[8], 8'h00, "second batch order");
        chk(pm.got[17], 8'h01, "last code kept");
        ovf_clr = 1'b1;
        @(negedge mclk);
        ovf_clr = 1'b0;
        cyc(2);
        chk(status.overflow, 1'b0, "overflow cleared");
        $display("test overflow done");
    endtask : t_ovf

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        cfg = '0;
        cfg.debounce = 2'h1;
        cfg.mod_code = '1;
        clk_shared_on = 1'b0;
        ghost_clr = 1'b0;
        ovf_clr = 1'b0;
        stall = 1'b0;
        pressed = '0;
        lowmask = '0;
        cyc(10);
        t_reset();
        t_order();
        t_shared();
        t_mod();
        t_ghost();
        t_ovf();
        finish_test();
    end
endmodule : test_kms_scanner

`default_nettype wire
